// *** accspi_host.sv ***
// Controller end: APB-driven serial master for the register port
//
// Rules of the register port, kept by the controller and the device
// [R1] Device only answers, never starts transfers
// [R2] Select always driven; high means I2C
// [R3] Ignore device output during writes
// [R4] Format bit six selects three-wire mode
// [R5] Serial clock no faster than 5 MHz
// [R6] Clock idles high, sample second edge
// [R7] Raise select before changing clock settings
// [R8] Select low per transfer, high after
// [R9] Clock held high between transfers
// [R10] Change on falling, capture on rising
// [R11] Multi_byte_flag set for several bytes; controller sends the CTRL MULTI bit as written, whatever the byte count
// [R12] Device steps pointer every eight clocks
// [R13] Separate transfers for non-consecutive registers
// [R14] Fast data rates need fast clock
// [R15] Deselected start-like traffic means I2C
// [R16] Hold data high while deselected
// [R17] First byte: read, multi, address
// [R18] Three-wire line driven only reading data
`timescale 1ns/10ps
`include "accspi_defines.svh"
module accspi_host
  import accspi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  accspi_link_if.host_end lk
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  accspi_host_state_type state, next_state;
  logic [2:0] div, next_div;
  logic [5:0] bit_idx, next_bit_idx;
  logic [5:0] last_idx, next_last_idx;
  logic [39:0] out_sh, next_out_sh;
  logic [31:0] in_sh, next_in_sh;
  logic [31:0] txd, next_txd;
  logic [31:0] rxd, next_rxd;
  logic rd_flag, next_rd_flag;
  logic multi, next_multi;
  logic tw, next_tw;
  logic [1:0] cnt, next_cnt;
  logic [5:0] addr, next_addr;
  logic busy, next_busy;
  logic done, next_done;
  logic next_cs_n, next_sclk, next_sdi, next_sdi_oe;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic sdo_s1, sdo_s2, sdi_s1, sdi_s2;
  logic half_up, gap_up, wr_take, go, done_clr, in_data;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_s1 <= 1'b1;
      sdo_s2 <= 1'b1;
      sdi_s1 <= 1'b1;
      sdi_s2 <= 1'b1;
    end else begin
      sdo_s1 <= lk.sdo_line;
      sdo_s2 <= sdo_s1;
      sdi_s1 <= lk.sdi_line;
      sdi_s2 <= sdi_s1;
    end
  end

  // --------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------
  always_comb begin
    // One wait state; writes act where pready is seen high
    wr_take = psel && penable && pready && pwrite;
    next_pready = psel && penable && !pready;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_txd = txd;
    go = 1'b0;
    done_clr = 1'b0;
    if (next_pready) begin
      if (paddr == `ACCSPI_CTRL_OFS) begin
        next_prdata = {18'h0_0000, addr, 2'b00, cnt, tw, multi, rd_flag,
                       1'b0};
      end else if (paddr == `ACCSPI_TXD_OFS) begin
        next_prdata = txd;
      end else if (paddr == `ACCSPI_RXD_OFS) begin
        next_prdata = rxd;
      end else if (paddr == `ACCSPI_STAT_OFS) begin
        next_prdata = {30'h0000_0000, done, busy};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (wr_take) begin
      if (paddr == `ACCSPI_CTRL_OFS) begin
        // Refused while a transfer runs
        go = pwdata[`ACCSPI_CTRL_START] && !busy;
      end else if (paddr == `ACCSPI_TXD_OFS) begin
        if (!busy) begin
          next_txd = pwdata;
        end
      end else if (paddr == `ACCSPI_STAT_OFS) begin
        done_clr = pwdata[`ACCSPI_STAT_DONE];
      end
    end
  end

  // --------------------------------------------------------------
  // Transfer engine
  // --------------------------------------------------------------
  always_comb begin
    half_up = div == 3'(`ACCSPI_HALF_CYC - 1); // [R5]
    gap_up = div == 3'(`ACCSPI_GAP_CYC - 1);
    in_data = bit_idx > 6'h07;
    next_state = state;
    next_div = div + 3'h1;
    next_bit_idx = bit_idx;
    next_last_idx = last_idx;
    next_out_sh = out_sh;
    next_in_sh = in_sh;
    next_rxd = rxd;
    next_rd_flag = rd_flag;
    next_multi = multi;
    next_tw = tw;
    next_cnt = cnt;
    next_addr = addr;
    next_busy = busy;
    next_done = done && !done_clr;
    next_cs_n = lk.cs_n;
    next_sclk = lk.sclk;
    next_sdi = lk.host_sdi;
    next_sdi_oe = lk.host_sdi_oe;
    case (state)
      HS_IDLE: begin
        next_div = 3'h0;
        next_sclk = 1'b1; // [R9]
        if (go) begin
          next_rd_flag = pwdata[`ACCSPI_CTRL_READ];
          next_multi = pwdata[`ACCSPI_CTRL_MULTI]; // [R11]
          next_tw = pwdata[`ACCSPI_CTRL_3W];
          next_cnt = pwdata[`ACCSPI_CTRL_CNT +: 2];
          next_addr = pwdata[`ACCSPI_CTRL_ADDR +: 6];
          next_out_sh = {pwdata[`ACCSPI_CTRL_READ],
                         pwdata[`ACCSPI_CTRL_MULTI],
                         pwdata[`ACCSPI_CTRL_ADDR +: 6], txd}; // [R17]
          next_last_idx = {1'b0, pwdata[`ACCSPI_CTRL_CNT +: 2], 3'b111}
                          + 6'h08;
          next_bit_idx = 6'h00;
          next_busy = 1'b1;
          next_cs_n = 1'b0; // [R8]
          next_state = HS_LEAD;
        end
      end
      HS_LEAD, HS_HIGH: begin
        if (half_up) begin
          // Falling edge: put the next bit out
          next_div = 3'h0;
          next_sclk = 1'b0; // [R6] [R10]
          next_sdi = out_sh[39];
          // Let go of the shared line while the device answers
          next_sdi_oe = !(tw && rd_flag && in_data); // [R18]
          next_state = HS_LOW;
        end
      end
      HS_LOW: begin
        if (half_up) begin
          // Rising edge: capture; write frames keep junk unused
          next_div = 3'h0;
          next_sclk = 1'b1;
          next_in_sh = {in_sh[30:0], tw ? sdi_s2 : sdo_s2}; // [R3] [R10]
          next_out_sh = {out_sh[38:0], 1'b0};
          next_bit_idx = bit_idx + 6'h01;
          next_state = (bit_idx == last_idx) ? HS_TAIL : HS_HIGH;
        end
      end
      HS_TAIL: begin
        if (half_up) begin
          // Each frame ends; new address needs a new frame
          next_div = 3'h0;
          next_cs_n = 1'b1; // [R8] [R13]
          next_sdi = 1'b1; // [R16]
          next_sdi_oe = 1'b1;
          next_state = HS_GAP;
        end
      end
      HS_GAP: begin
        if (gap_up) begin
          next_rxd = in_sh;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = HS_IDLE;
        end
      end
      default: begin
        next_state = HS_IDLE;
      end
    endcase
  end

  // Select always driven and idles high; mode fixed at clock polarity 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
      div <= 3'h0;
      bit_idx <= 6'h00;
      last_idx <= 6'h00;
      out_sh <= 40'h00_0000_0000;
      in_sh <= 32'h0000_0000;
      txd <= 32'h0000_0000;
      rxd <= 32'h0000_0000;
      rd_flag <= 1'b0;
      multi <= 1'b0;
      tw <= 1'b0;
      cnt <= 2'h0;
      addr <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
      lk.cs_n <= 1'b1; // [R2] [R7]
      lk.sclk <= 1'b1;
      lk.host_sdi <= 1'b1;
      lk.host_sdi_oe <= 1'b1;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      bit_idx <= next_bit_idx;
      last_idx <= next_last_idx;
      out_sh <= next_out_sh;
      in_sh <= next_in_sh;
      txd <= next_txd;
      rxd <= next_rxd;
      rd_flag <= next_rd_flag;
      multi <= next_multi;
      tw <= next_tw;
      cnt <= next_cnt;
      addr <= next_addr;
      busy <= next_busy;
      done <= next_done;
      lk.cs_n <= next_cs_n;
      lk.sclk <= next_sclk;
      lk.host_sdi <= next_sdi;
      lk.host_sdi_oe <= next_sdi_oe;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Any output data rate; link runs at 5 MHz, enough for all [R14]
endmodule

// *** accspi_defines.svh ***
// Shared constants for the serial register port and its controller
`ifndef ACCSPI_DEFINES_SVH
`define ACCSPI_DEFINES_SVH

// ----------------------------------------------------------------
// Device register map
// ----------------------------------------------------------------
`define ACCSPI_FMT_ADDR 6'h31
`define ACCSPI_FMT_3W_BIT 6
`define ACCSPI_FMT_RESET 8'h00

// ----------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------
`define ACCSPI_PCLK_HZ 40000000
`define ACCSPI_PCLK_NS 25
`define ACCSPI_SCLK_MAX_HZ 5000000
`define ACCSPI_CS_GAP_NS 150
`define ACCSPI_HALF_CYC \
  ((`ACCSPI_PCLK_HZ + 2 * `ACCSPI_SCLK_MAX_HZ - 1) / \
   (2 * `ACCSPI_SCLK_MAX_HZ))
`define ACCSPI_GAP_CYC \
  ((`ACCSPI_CS_GAP_NS + `ACCSPI_PCLK_NS - 1) / `ACCSPI_PCLK_NS)

// ----------------------------------------------------------------
// Controller APB map
// ----------------------------------------------------------------
`define ACCSPI_CTRL_OFS 8'h00
`define ACCSPI_TXD_OFS 8'h04
`define ACCSPI_RXD_OFS 8'h08
`define ACCSPI_STAT_OFS 8'h0c
`define ACCSPI_CTRL_START 0
`define ACCSPI_CTRL_READ 1
`define ACCSPI_CTRL_MULTI 2
`define ACCSPI_CTRL_3W 3
`define ACCSPI_CTRL_CNT 4
`define ACCSPI_CTRL_ADDR 8
`define ACCSPI_STAT_BUSY 0
`define ACCSPI_STAT_DONE 1

`endif

// *** accspi_pkg.sv ***
// Types for the two ends of the serial register port: host states and device phases
package accspi_pkg;
  typedef enum logic [2:0] {
    HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP
  } accspi_host_state_type;
  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_OVER} accspi_phase_type;
endpackage

// *** accspi_link_if.sv ***
// Serial link wires between controller and device
`timescale 1ns/10ps
interface accspi_link_if;
  logic cs_n;
  logic sclk;
  logic host_sdi;
  logic host_sdi_oe;
  logic dev_out;
  logic dev_sdo_oe;
  logic dev_sdio_oe;
  logic sdi_line;
  logic sdo_line;

  // Undriven lines rest high, as with a pull-up
  assign sdi_line = host_sdi_oe ? host_sdi : (dev_sdio_oe ? dev_out : 1'b1);
  assign sdo_line = dev_sdo_oe ? dev_out : 1'b1;

  modport host_end (
    output cs_n,
    output sclk,
    output host_sdi,
    output host_sdi_oe,
    input sdi_line,
    input sdo_line
  );
  modport dev_end (
    input cs_n,
    input sclk,
    input sdi_line,
    output dev_out,
    output dev_sdo_oe,
    output dev_sdio_oe
  );
endinterface

// *** accspi_device.sv ***
// Device end: serial slave reaching the byte register array
`timescale 1ns/10ps
`include "accspi_defines.svh"
module accspi_device
  import accspi_pkg::*;
(
  accspi_link_if.dev_end lk,
  input wire logic presetn,
  output logic three_wire,
  output logic i2c_start_seen
);
  // --------------------------------------------------------------
  // Frame state on the rising serial clock
  // --------------------------------------------------------------
  accspi_phase_type phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] in_sh, next_in_sh;
  logic is_read, next_is_read;
  logic multi, next_multi;
  logic [5:0] ptr, next_ptr;
  logic [7:0] tx_byte, next_tx_byte;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] fmt, next_fmt;
  logic [7:0] mem [0:63];
  logic next_out, next_sdo_oe, next_sdio_oe, next_i2c;
  logic [7:0] full;

  function automatic logic [7:0] rd(input logic [5:0] a);
    if (a == `ACCSPI_FMT_ADDR) begin
      rd = fmt;
    end else begin
      rd = mem[a];
    end
  endfunction

  always_comb begin
    full = {in_sh, lk.sdi_line};
    next_phase = phase;
    next_bit_cnt = bit_cnt + 3'h1; // [R10]
    next_in_sh = full[6:0];
    next_is_read = is_read;
    next_multi = multi;
    next_ptr = ptr;
    next_tx_byte = tx_byte;
    wr_en = 1'b0;
    wr_addr = ptr;
    wr_data = full;
    if (bit_cnt == 3'h7) begin
      case (phase)
        PH_CMD: begin
          // First byte: read flag, multi_byte_flag, address
          next_is_read = full[7]; // [R17]
          next_multi = full[6];
          next_ptr = full[5:0];
          next_tx_byte = rd(full[5:0]);
          next_phase = PH_DATA;
        end
        PH_DATA: begin
          wr_en = !is_read;
          if (multi) begin
            next_ptr = ptr + 6'h01; // [R12]
            next_tx_byte = rd(ptr + 6'h01);
          end else begin
            next_phase = PH_OVER;
          end
        end
        default: begin
          next_phase = PH_OVER;
        end
      endcase
    end
  end

  // Raised chip select ends the frame at once
  always_ff @(posedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      phase <= PH_CMD;
      bit_cnt <= 3'h0;
      in_sh <= 7'h00;
      is_read <= 1'b0;
      multi <= 1'b0;
      ptr <= 6'h00;
      tx_byte <= 8'h00;
    end else begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      in_sh <= next_in_sh;
      is_read <= next_is_read;
      multi <= next_multi;
      ptr <= next_ptr;
      tx_byte <= next_tx_byte;
    end
  end

  // --------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------
  always_comb begin
    next_fmt = fmt;
    if (wr_en && wr_addr == `ACCSPI_FMT_ADDR) begin
      next_fmt = wr_data;
    end
  end

  always_ff @(posedge lk.sclk or negedge presetn) begin
    if (!presetn) begin
      fmt <= `ACCSPI_FMT_RESET;
    end else begin
      fmt <= next_fmt;
    end
  end

  // Array has no reset; software sets up what it needs
  always_ff @(posedge lk.sclk) begin
    if (wr_en && wr_addr != `ACCSPI_FMT_ADDR) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign three_wire = fmt[`ACCSPI_FMT_3W_BIT];

  // --------------------------------------------------------------
  // Output drive on the falling serial clock
  // --------------------------------------------------------------
  always_comb begin
    next_out = tx_byte[~bit_cnt]; // [R10]
    // Slave only: drives data, never clock or select
    next_sdo_oe = !three_wire; // [R1] [R4]
    next_sdio_oe = three_wire && is_read && phase == PH_DATA; // [R18]
  end

  always_ff @(negedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      lk.dev_out <= 1'b1;
      lk.dev_sdo_oe <= 1'b0;
      lk.dev_sdio_oe <= 1'b0;
    end else begin
      lk.dev_out <= next_out; // [R6]
      lk.dev_sdo_oe <= next_sdo_oe;
      lk.dev_sdio_oe <= next_sdio_oe;
    end
  end

  // --------------------------------------------------------------
  // Deselected: a data fall under high clock is a start
  // --------------------------------------------------------------
  always_comb begin
    next_i2c = i2c_start_seen | (lk.cs_n & lk.sclk); // [R2] [R15]
  end

  always_ff @(negedge lk.sdi_line or negedge presetn) begin
    if (!presetn) begin
      i2c_start_seen <= 1'b0;
    end else begin
      i2c_start_seen <= next_i2c;
    end
  end
endmodule

// *** accspi_properties.sv ***
// Checker on the serial wires joining controller and device
`timescale 1ns/10ps
module accspi_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_sdi,
  input wire logic host_sdi_oe,
  input wire logic dev_sdo_oe,
  input wire logic dev_sdio_oe,
  input wire logic sdi_line
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Frame steps
  // ----------------------------------------------------------------
  sequence lead_s;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence low_half_s;
    !sclk [*4] ##1 sclk;
  endsequence

  // ----------------------------------------------------------------
  // Wire rules
  // ----------------------------------------------------------------
  AST_SCLK_IDLE: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  AST_CS_LEAD: assert property ($fell(cs_n) |-> lead_s)
    else $error("first clock fall not four cycles after select");
  AST_HALF_LOW: assert property ($fell(sclk) |-> low_half_s)
    else $error("serial clock low phase not four cycles");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("deselect gap shorter than six cycles");
  AST_DATA_FALL: assert property (
    (!cs_n && host_sdi_oe && $changed(host_sdi)) |-> $fell(sclk))
    else $error("host data moved off a falling clock");
  AST_SDI_REST: assert property (cs_n |-> sdi_line)
    else $error("data input not high while deselected");
  AST_DEV_QUIET: assert property (cs_n |-> !dev_sdo_oe && !dev_sdio_oe)
    else $error("device drives while deselected");
  AST_ONE_DRIVER: assert property (dev_sdio_oe |-> !host_sdi_oe)
    else $error("both ends drive the shared data line");
  AST_THREE_WIRE: assert property (dev_sdio_oe |-> !dev_sdo_oe)
    else $error("separate output driven in three-wire mode");
endmodule

// *** spi_slave_register_port_tb.sv ***
// Self-checking bench: controller and device joined over the link
`timescale 1ns/10ps
`include "accspi_defines.svh"
module spi_slave_register_port_tb
  import accspi_pkg::*;
;
  typedef struct {logic [32:0] m; logic [32:0] e;} accspi_note_type;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic three_wire;
  logic i2c_start_seen;
  logic [31:0] q;
  logic [31:0] w;
  logic [31:0] v;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 9;
  accspi_note_type notes[$];

  always #12.5 pclk = ~pclk;

  accspi_link_if lk ();
  accspi_host accspi_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lk(lk.host_end));
  accspi_device accspi_device_i (.lk(lk.dev_end), .presetn(presetn),
    .three_wire(three_wire), .i2c_start_seen(i2c_start_seen));
  accspi_properties accspi_properties_i (.pclk(pclk), .presetn(presetn),
    .cs_n(lk.cs_n), .sclk(lk.sclk), .host_sdi(lk.host_sdi),
    .host_sdi_oe(lk.host_sdi_oe), .dev_sdo_oe(lk.dev_sdo_oe),
    .dev_sdio_oe(lk.dev_sdio_oe), .sdi_line(lk.sdi_line));

  // ----------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------
  task check(input string what, input logic [32:0] seen,
             input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Oldest note pairs with each answer; mask hides unsampled bits
  always @(posedge pclk) begin
    if (pready === 1'b1 && notes.size() > 0) begin
      check("apb answer", {pslverr, prdata} & notes[0].m,
            notes[0].e & notes[0].m);
      void'(notes.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Bus and frame tasks
  // ----------------------------------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] m, input logic [32:0] e);
    notes.push_back('{m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task xfer(input logic rd, input logic mb, input logic tw,
            input logic [1:0] cm1, input logic [5:0] ad,
            input logic [31:0] d);
    apb(1'b1, `ACCSPI_TXD_OFS, d, 33'h1_0000_0000, '0);
    apb(1'b1, `ACCSPI_CTRL_OFS,
        {18'h0_0000, ad, 2'b00, cm1, tw, mb, rd, 1'b1}, 33'h1_0000_0000, '0);
    // Busy: a new start and new data must both be refused
    apb(1'b1, `ACCSPI_CTRL_OFS,
        {18'h0_0000, ~ad, 2'b00, cm1, tw, mb, rd, 1'b1}, 33'h1_0000_0000, '0);
    apb(1'b1, `ACCSPI_TXD_OFS, ~d, 33'h1_0000_0000, '0);
    // Poll until the frame reports done
    do apb(1'b0, `ACCSPI_STAT_OFS, '0, '0, '0); while (q[1] !== 1'b1);
    apb(1'b1, `ACCSPI_STAT_OFS, 32'h0000_0002, 33'h1_0000_0000, '0);
    apb(1'b0, `ACCSPI_STAT_OFS, '0, 33'h1_ffff_ffff, '0);
    apb(1'b0, `ACCSPI_TXD_OFS, '0, 33'h1_ffff_ffff, {1'b0, d});
    apb(1'b0, `ACCSPI_CTRL_OFS, '0, 33'h1_ffff_ffff,
        {19'h0_0000, ad, 2'b00, cm1, tw, mb, rd, 1'b0});
  endtask

  task rd_rxd(input int nb, input logic [31:0] e);
    apb(1'b0, `ACCSPI_RXD_OFS, '0,
        {1'b1, 32'hffff_ffff >> (32 - 8 * nb)}, {1'b0, e});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    // Scheduled, so every async reset sees a real falling edge
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ACCSPI_STAT_OFS, '0, 33'h1_ffff_ffff, '0);
    // Unmapped place answers with an error and zero data
    apb(1'b0, 8'h10, '0, 33'h1_ffff_ffff, 33'h1_0000_0000);
    apb(1'b1, 8'h14, 32'h1234_5678, 33'h1_0000_0000, 33'h1_0000_0000);
    w = $random(seed);
    v = $random(seed);
    xfer(1'b0, 1'b1, 1'b0, 2'd3, 6'h20, w);
    xfer(1'b1, 1'b1, 1'b0, 2'd3, 6'h20, '0);
    rd_rxd(4, w);
    xfer(1'b0, 1'b0, 1'b0, 2'd0, 6'h29, v);
    // Second byte without the flag must not reach the next register
    xfer(1'b0, 1'b0, 1'b0, 2'd1, 6'h28, ~w);
    xfer(1'b1, 1'b1, 1'b0, 2'd1, 6'h28, '0);
    rd_rxd(2, {16'h0000, ~w[31:24], v[31:24]});
    xfer(1'b0, 1'b0, 1'b0, 2'd0, `ACCSPI_FMT_ADDR, 32'h4000_0000);
    check("three_wire", {32'h0000_0000, three_wire}, 33'h0_0000_0001);
    xfer(1'b1, 1'b1, 1'b1, 2'd3, 6'h20, '0);
    rd_rxd(4, w);
    xfer(1'b1, 1'b0, 1'b1, 2'd0, 6'h29, '0);
    rd_rxd(1, {24'h00_0000, v[31:24]});
    xfer(1'b0, 1'b0, 1'b1, 2'd0, `ACCSPI_FMT_ADDR, '0);
    check("three_wire", {32'h0000_0000, three_wire}, 33'h0_0000_0000);
    xfer(1'b1, 1'b0, 1'b0, 2'd0, `ACCSPI_FMT_ADDR, '0);
    rd_rxd(1, 32'h0000_0000);
    check("i2c start", {32'h0000_0000, i2c_start_seen}, '0);
    @(posedge pclk);
    test_done;
  end

  // Whole run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    test_done;
  end
endmodule
